/* File: logic/sys_config_map.svh */
// Register offsets, field positions and reset values of the system config block.
// Assumes inclusion by bare name from package and modules.
`ifndef SYS_CONFIG_MAP_SVH
`define SYS_CONFIG_MAP_SVH

`define OFS_INPUT_SYNC_BYPASS_LOW 12'h00C
`define OFS_INPUT_SYNC_BYPASS_HIGH 12'h010
`define OFS_DEBUG_PORT_OVERRIDE 12'h014
`define OFS_MEMORY_POWER_DOWN 12'h018

`define LOW_PIN_COUNT 30
`define HIGH_PIN_COUNT 6
`define SYNC_STAGES 2
`define MEM_COUNT 8

`define BIT_CORE1_ATTACH 7
`define BIT_CORE1_CLOCK 6
`define BIT_CORE1_DATA_IN 5
`define BIT_CORE1_DATA_OUT 4
`define BIT_CORE0_ATTACH 3
`define BIT_CORE0_CLOCK 2
`define BIT_CORE0_DATA_IN 1
`define BIT_CORE0_DATA_OUT 0

`define RST_INPUT_SYNC_BYPASS_LOW 30'h00000000
`define RST_INPUT_SYNC_BYPASS_HIGH 6'h00
`define RST_DEBUG_OVERRIDE_WR 8'h66
`define RST_MEMORY_POWER_DOWN 8'h00

`endif

/* File: logic/sys_config_pkg.sv */
// Types shared by the system config block.
// Assumes sys_config_map.svh on the include path.
`include "sys_config_map.svh"
package sys_config_pkg;
  typedef logic [`LOW_PIN_COUNT+`HIGH_PIN_COUNT-1:0] gpio_vec_t;
  typedef logic [`MEM_COUNT-1:0] mem_vec_t;
  typedef struct packed {
    logic clk;
    logic data_in;
  } debug_in_s;
endpackage

/* File: logic/gpio_sync_if.sv */
// Interface carrying GPIO input path signals between top and sync stage.
// Assumes sys_config_pkg compiled first.
`timescale 1ns/1ps
interface gpio_sync_if;
  import sys_config_pkg::*;
  gpio_vec_t pins;
  gpio_vec_t bypass;
  gpio_vec_t to_core;
  modport top (output pins, output bypass, input to_core);
  modport sync (input pins, input bypass, output to_core);
endinterface

/* File: logic/gpio_input_sync.sv */
// Per-pin input synchroniser with a software bypass.
// Assumes one system clock; pins are asynchronous unless bypassed.
`timescale 1ns/1ps
module gpio_input_sync #(
  parameter int WIDTH = 36
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // GPIO path
  gpio_sync_if.sync io
);
  import sys_config_pkg::*;

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] sync_out_reg;

  // Two-flop synchroniser; first stage read only by second
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      stable_reg <= '0;
    end else begin
      meta_reg <= io.pins;
      stable_reg <= meta_reg;
    end
  end

  // Core input register; bypassed pins skip both sync stages
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sync_out_reg <= '0;
    end else begin
      sync_out_reg <= (io.bypass & io.pins) | (~io.bypass & stable_reg);
    end
  end

  assign io.to_core = sync_out_reg;
endmodule

/* File: logic/sys_config_regs.sv */
// System config register bank: GPIO sync bypass, debug port override, memory power down.
// Assumes an APB master on core_clk_i and one synchronous active-low reset.
//
// Contract
// - Low bypass bits 29:0 route GPIO 0-29 to the core input register without sync.
// - High bypass bits 5:0 do the same for GPIO 30-35.
// - A bypassed pin reaches the core input register two cycles sooner.
// - Bit 7 detaches core 1 debug from pads and hands it to register bits.
// - When core 1 attached, bit 6 drives its debug clock; resets to 1.
// - When core 1 attached, bit 5 drives its debug data input; resets to 1.
// - Bit 4 reads core 1 debug data output.
// - Bit 3 detaches core 0 debug from pads and hands it to register bits.
// - When core 0 attached, bit 2 drives its debug clock; resets to 1.
// - When core 0 attached, bit 1 drives its debug data input; resets to 1.
// - Bit 0 reads core 0 debug data output.
// - Memory power-down bits 0-5 SRAM banks, 6 USB memory, 7 ROM; reset 0.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "sys_config_map.svh"
module sys_config_regs (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // GPIO input path
  input wire sys_config_pkg::gpio_vec_t gpio_pins_i,
  output sys_config_pkg::gpio_vec_t gpio_to_core_o,
  // Debug pads and cores
  input wire sys_config_pkg::debug_in_s core0_pad_i,
  input wire sys_config_pkg::debug_in_s core1_pad_i,
  input wire logic core0_debug_data_out_i,
  input wire logic core1_debug_data_out_i,
  output sys_config_pkg::debug_in_s core0_debug_o,
  output sys_config_pkg::debug_in_s core1_debug_o,
  output logic core0_pad_detached_o,
  output logic core1_pad_detached_o,
  // Memory power
  output sys_config_pkg::mem_vec_t memory_power_down_o
);
  import sys_config_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  logic [`LOW_PIN_COUNT-1:0] input_sync_bypass_low_reg;
  logic [`HIGH_PIN_COUNT-1:0] input_sync_bypass_high_reg;
  logic core1_debug_attach_reg;
  logic core1_debug_clock_drive_reg;
  logic core1_debug_data_in_drive_reg;
  logic core0_debug_attach_reg;
  logic core0_debug_clock_drive_reg;
  logic core0_debug_data_in_drive_reg;
  logic [`MEM_COUNT-1:0] memory_power_down_reg;
  logic core0_dout_meta_reg;
  logic core0_dout_reg;
  logic core1_dout_meta_reg;
  logic core1_dout_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] wmask;
  logic [31:0] wdata_masked;
  logic wr_en;
  logic rd_en;
  logic addr_hit;

  // Byte-lane mask from strobes
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // Merge new write data into old register contents
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // ****************************************
  // APB decode
  // ****************************************
  always_comb begin
    case (paddr_i)
      `OFS_INPUT_SYNC_BYPASS_LOW,
      `OFS_INPUT_SYNC_BYPASS_HIGH,
      `OFS_DEBUG_PORT_OVERRIDE,
      `OFS_MEMORY_POWER_DOWN: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign wr_en = psel_i & penable_i & pwrite_i & addr_hit;
  assign rd_en = psel_i & penable_i & ~pwrite_i;
  assign wmask = lane_mask(pstrb_i);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_hit;

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      input_sync_bypass_low_reg <= `RST_INPUT_SYNC_BYPASS_LOW;
    end else if (wr_en && paddr_i == `OFS_INPUT_SYNC_BYPASS_LOW) begin
      input_sync_bypass_low_reg <= wdata_masked[`LOW_PIN_COUNT-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      input_sync_bypass_high_reg <= `RST_INPUT_SYNC_BYPASS_HIGH;
    end else if (wr_en && paddr_i == `OFS_INPUT_SYNC_BYPASS_HIGH) begin
      input_sync_bypass_high_reg <= wdata_masked[`HIGH_PIN_COUNT-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      core1_debug_attach_reg <= 1'b0;
      core1_debug_clock_drive_reg <= 1'b1;
      core1_debug_data_in_drive_reg <= 1'b1;
      core0_debug_attach_reg <= 1'b0;
      core0_debug_clock_drive_reg <= 1'b1;
      core0_debug_data_in_drive_reg <= 1'b1;
    end else if (wr_en && paddr_i == `OFS_DEBUG_PORT_OVERRIDE) begin
      core1_debug_attach_reg <= wdata_masked[`BIT_CORE1_ATTACH];
      core1_debug_clock_drive_reg <= wdata_masked[`BIT_CORE1_CLOCK];
      core1_debug_data_in_drive_reg <= wdata_masked[`BIT_CORE1_DATA_IN];
      core0_debug_attach_reg <= wdata_masked[`BIT_CORE0_ATTACH];
      core0_debug_clock_drive_reg <= wdata_masked[`BIT_CORE0_CLOCK];
      core0_debug_data_in_drive_reg <= wdata_masked[`BIT_CORE0_DATA_IN];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      memory_power_down_reg <= `RST_MEMORY_POWER_DOWN;
    end else if (wr_en && paddr_i == `OFS_MEMORY_POWER_DOWN) begin
      memory_power_down_reg <= wdata_masked[`MEM_COUNT-1:0];
    end
  end

  // Old contents for the addressed word, used for partial-strobe merge
  always_comb begin
    wdata_masked = merge(rdata_next, pwdata_i, wmask);
  end

  // ****************************************
  // Debug data out observation
  // ****************************************
  // Core debug outputs may run on the pad clock, so resync them
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      core0_dout_meta_reg <= 1'b0;
      core0_dout_reg <= 1'b0;
      core1_dout_meta_reg <= 1'b0;
      core1_dout_reg <= 1'b0;
    end else begin
      core0_dout_meta_reg <= core0_debug_data_out_i;
      core0_dout_reg <= core0_dout_meta_reg;
      core1_dout_meta_reg <= core1_debug_data_out_i;
      core1_dout_reg <= core1_dout_meta_reg;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rdata_next = 32'h00000000;
    case (paddr_i)
      `OFS_INPUT_SYNC_BYPASS_LOW: rdata_next[`LOW_PIN_COUNT-1:0] = input_sync_bypass_low_reg;
      `OFS_INPUT_SYNC_BYPASS_HIGH: rdata_next[`HIGH_PIN_COUNT-1:0] = input_sync_bypass_high_reg;
      `OFS_DEBUG_PORT_OVERRIDE: begin
        rdata_next[`BIT_CORE1_ATTACH] = core1_debug_attach_reg;
        rdata_next[`BIT_CORE1_CLOCK] = core1_debug_clock_drive_reg;
        rdata_next[`BIT_CORE1_DATA_IN] = core1_debug_data_in_drive_reg;
        rdata_next[`BIT_CORE1_DATA_OUT] = core1_dout_reg;
        rdata_next[`BIT_CORE0_ATTACH] = core0_debug_attach_reg;
        rdata_next[`BIT_CORE0_CLOCK] = core0_debug_clock_drive_reg;
        rdata_next[`BIT_CORE0_DATA_IN] = core0_debug_data_in_drive_reg;
        rdata_next[`BIT_CORE0_DATA_OUT] = core0_dout_reg;
      end
      `OFS_MEMORY_POWER_DOWN: rdata_next[`MEM_COUNT-1:0] = memory_power_down_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end

  // Read data captured in setup phase; stays until next read
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      prdata_reg <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_reg <= rdata_next;
    end
  end

  assign prdata_o = rd_en ? prdata_reg : 32'h00000000;

  // ****************************************
  // Debug port steering
  // ****************************************
  always_comb begin
    core1_debug_o = core1_pad_i;
    core0_debug_o = core0_pad_i;
    if (core1_debug_attach_reg) begin
      core1_debug_o.clk = core1_debug_clock_drive_reg;
      core1_debug_o.data_in = core1_debug_data_in_drive_reg;
    end
    if (core0_debug_attach_reg) begin
      core0_debug_o.clk = core0_debug_clock_drive_reg;
      core0_debug_o.data_in = core0_debug_data_in_drive_reg;
    end
  end

  assign core1_pad_detached_o = core1_debug_attach_reg;
  assign core0_pad_detached_o = core0_debug_attach_reg;
  assign memory_power_down_o = memory_power_down_reg;

  // ****************************************
  // GPIO input path
  // ****************************************
  gpio_sync_if gpio_bus ();

  assign gpio_bus.pins = gpio_pins_i;
  assign gpio_bus.bypass = {input_sync_bypass_high_reg, input_sync_bypass_low_reg};
  assign gpio_to_core_o = gpio_bus.to_core;

  gpio_input_sync #(
    .WIDTH(`LOW_PIN_COUNT + `HIGH_PIN_COUNT)
  ) u_gpio_input_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .io(gpio_bus.sync)
  );
endmodule

/* File: sim/sys_config_regs_props.sv */
// Checker for the system config register bank, bound to its ports.
// Assumes APB writes merge into the fields by byte strobe.
`timescale 1ns/1ps
`include "sys_config_map.svh"
module sys_config_regs_props (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  // Pins, debug, memories
  input wire sys_config_pkg::gpio_vec_t gpio_pins_i,
  input wire sys_config_pkg::gpio_vec_t gpio_to_core_o,
  input wire sys_config_pkg::debug_in_s core0_pad_i,
  input wire sys_config_pkg::debug_in_s core1_pad_i,
  input wire sys_config_pkg::debug_in_s core0_debug_o,
  input wire sys_config_pkg::debug_in_s core1_debug_o,
  input wire logic core0_pad_detached_o,
  input wire logic core1_pad_detached_o,
  input wire sys_config_pkg::mem_vec_t memory_power_down_o
);
  import sys_config_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic wr;
  logic mapped;
  logic [31:0] lanes;
  logic [35:0] byp_reg;
  logic [7:0] dbg_reg;
  logic [7:0] mem_reg;
  logic [1:0] up_reg;
  assign wr = psel_i && penable_i && pwrite_i;
  assign lanes = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  assign mapped = paddr_i inside {`OFS_INPUT_SYNC_BYPASS_LOW, `OFS_INPUT_SYNC_BYPASS_HIGH,
    `OFS_DEBUG_PORT_OVERRIDE, `OFS_MEMORY_POWER_DOWN};
  // Shadow of the writable fields, merged by byte lane
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      byp_reg <= '0;
      dbg_reg <= `RST_DEBUG_OVERRIDE_WR;
      mem_reg <= 8'h00;
      up_reg <= 2'h0;
    end else begin
      up_reg <= (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
      if (wr && paddr_i == `OFS_INPUT_SYNC_BYPASS_LOW) begin
        byp_reg[29:0] <= (byp_reg[29:0] & ~lanes[29:0]) | (pwdata_i[29:0] & lanes[29:0]);
      end
      if (wr && paddr_i == `OFS_INPUT_SYNC_BYPASS_HIGH) begin
        byp_reg[35:30] <= (byp_reg[35:30] & ~lanes[5:0]) | (pwdata_i[5:0] & lanes[5:0]);
      end
      if (wr && paddr_i == `OFS_DEBUG_PORT_OVERRIDE) begin
        dbg_reg <= (dbg_reg & ~lanes[7:0]) | (pwdata_i[7:0] & lanes[7:0]);
      end
      if (wr && paddr_i == `OFS_MEMORY_POWER_DOWN) begin
        mem_reg <= (mem_reg & ~lanes[7:0]) | (pwdata_i[7:0] & lanes[7:0]);
      end
    end
  end
  AST_BYPASS_PATH: assert property (
    ((gpio_to_core_o ^ $past(gpio_pins_i)) & $past(byp_reg)) == '0)
    else $error("bypassed pin not one cycle");
  AST_SYNC_PATH: assert property (up_reg == 2'h3 |->
    ((gpio_to_core_o ^ $past(gpio_pins_i, 3)) & ~$past(byp_reg)) == '0)
    else $error("synced pin not three cycles");
  AST_DETACH: assert property (
    {core1_pad_detached_o, core0_pad_detached_o} == {dbg_reg[7], dbg_reg[3]})
    else $error("detach flags wrong");
  AST_C1_DRIVE: assert property (
    core1_pad_detached_o |-> core1_debug_o == dbg_reg[6:5])
    else $error("core1 drive wrong");
  AST_C0_DRIVE: assert property (
    core0_pad_detached_o |-> core0_debug_o == dbg_reg[2:1])
    else $error("core0 drive wrong");
  AST_C1_PADS: assert property (!core1_pad_detached_o |-> core1_debug_o == core1_pad_i)
    else $error("core1 not on pads");
  AST_C0_PADS: assert property (!core0_pad_detached_o |-> core0_debug_o == core0_pad_i)
    else $error("core0 not on pads");
  AST_MEM_PD: assert property (memory_power_down_o == mem_reg)
    else $error("power down wrong");
  AST_UNMAPPED: assert property (
    psel_i && penable_i && !mapped |-> pslverr_o && prdata_o == '0)
    else $error("unmapped access wrong");
  cover property (wr && paddr_i == `OFS_DEBUG_PORT_OVERRIDE && pwdata_i[7]);
  cover property (byp_reg != '0);
  cover property (psel_i && penable_i && !mapped);
endmodule

/* File: sim/core_side_model.sv */
// Far side: GPIO pins, debug pads and two cores answering on debug data.
// Assumes the core clock; pins and pads change at random each cycle.
`timescale 1ns/1ps
module core_side_model (
  // Clock
  input wire logic core_clk_i,
  // Debug inputs seen by the cores
  input wire sys_config_pkg::debug_in_s core0_debug_i,
  input wire sys_config_pkg::debug_in_s core1_debug_i,
  // Pins, pads and core outputs
  output sys_config_pkg::gpio_vec_t gpio_pins_o,
  output sys_config_pkg::debug_in_s core0_pad_o,
  output sys_config_pkg::debug_in_s core1_pad_o,
  output logic core0_dout_o,
  output logic core1_dout_o
);
  import sys_config_pkg::*;
  integer seed = 71;
  logic [63:0] rnd;
  // Core answers with its inverted data input
  assign core0_dout_o = ~core0_debug_i.data_in;
  assign core1_dout_o = ~core1_debug_i.data_in;
  initial begin
    gpio_pins_o = '0;
    core0_pad_o = '0;
    core1_pad_o = '0;
  end
  always @(posedge core_clk_i) begin
    rnd = {$random(seed), $random(seed)};
    gpio_pins_o <= rnd[35:0];
    core0_pad_o <= rnd[37:36];
    core1_pad_o <= rnd[39:38];
  end
endmodule

/* File: sim/sys_config_sync_debug_pwr_test.sv */
// Testbench of the system config register bank.
// Assumes the core side model and the bound checker.
`timescale 1ns/1ps
`include "sys_config_map.svh"
module sys_config_sync_debug_pwr_test;
  import sys_config_pkg::*;
  logic core_clk_i = 0;
  logic rst_n_i = 0;
  logic psel_i = 0;
  logic penable_i = 0;
  logic pwrite_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0;
  logic [3:0] pstrb_i = 4'hF;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic pready_o, pslverr_o, err, core0_dout, core1_dout;
  logic core0_pad_detached_o, core1_pad_detached_o;
  gpio_vec_t gpio_pins_i, gpio_to_core_o;
  debug_in_s core0_pad_i, core1_pad_i, core0_debug_o, core1_debug_o;
  mem_vec_t memory_power_down_o;
  int error_cnt = 0;
  int cmp_count = 0;
  integer seed = 71;
  logic [11:0] addr_tab [4] = '{`OFS_INPUT_SYNC_BYPASS_LOW, `OFS_INPUT_SYNC_BYPASS_HIGH,
    `OFS_DEBUG_PORT_OVERRIDE, `OFS_MEMORY_POWER_DOWN};
  logic [31:0] mask_tab [4] = '{32'h3FFFFFFF, 32'h0000003F, 32'h000000EE, 32'h000000FF};
  sys_config_regs i_sys_config_regs (.core_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .gpio_pins_i,
    .gpio_to_core_o, .core0_pad_i, .core1_pad_i, .core0_debug_data_out_i(core0_dout),
    .core1_debug_data_out_i(core1_dout), .core0_debug_o, .core1_debug_o,
    .core0_pad_detached_o, .core1_pad_detached_o, .memory_power_down_o);
  core_side_model i_core_side_model (.core_clk_i, .core0_debug_i(core0_debug_o),
    .core1_debug_i(core1_debug_o), .gpio_pins_o(gpio_pins_i), .core0_pad_o(core0_pad_i),
    .core1_pad_o(core1_pad_i), .core0_dout_o(core0_dout), .core1_dout_o(core1_dout));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge core_clk_i);
      if (pready_o === 1'b1) break;
    end
    if (n == 16) begin
      error_cnt++;
      end_of_test();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Read value: writable fields, view bits invert the driven data
  function automatic logic [31:0] exp_rd(int i, logic [31:0] d);
    logic [31:0] e;
    e = d & mask_tab[i];
    if (i == 2) e = e | {27'h0, ~d[5], 3'h0, ~d[1]};
    return e;
  endfunction
  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    logic [31:0] d;
    int i;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 4; i++) begin
      apb(1'b0, addr_tab[i], '0);
      chk("rst", rd & mask_tab[i], (i == 2) ? 32'h66 : 32'h0);
    end
    for (i = 0; i < 16; i++) begin
      d = (i < 4) ? 32'hFFFFFFFF : $random(seed);
      if (i % 4 == 2) d = d | 32'h88;
      apb(1'b1, addr_tab[i % 4], d);
      repeat (4) @(posedge core_clk_i);
      #1;
      if (i % 4 == 3) chk("power", {24'h0, memory_power_down_o}, d & 32'hFF);
      apb(1'b0, addr_tab[i % 4], '0);
      chk("readback", rd, exp_rd(i % 4, d));
      chk("slverr", {31'h0, err}, 32'h0);
    end
    apb(1'b1, addr_tab[2], 32'h66);
    #1;
    chk("pads", {30'h0, core1_debug_o}, {30'h0, core1_pad_i});
    for (i = 0; i < 3; i++) begin
      apb(1'b1, 12'h01C + 12'(i * 4), 32'hFFFFFFFF);
      apb(1'b0, 12'h01C + 12'(i * 4), '0);
      chk("unmapped", rd, 32'h0);
      chk("unmapped_err", {31'h0, err}, 32'h1);
    end
    apb(1'b1, addr_tab[0], 32'hFFFFFFFF);
    pstrb_i <= 4'h5;
    apb(1'b1, addr_tab[0], '0);
    pstrb_i <= 4'hF;
    apb(1'b0, addr_tab[0], '0);
    chk("strobe", rd, 32'h3F00FF00);
    apb(1'b1, addr_tab[0], '0);
    apb(1'b1, addr_tab[1], '0);
    apb(1'b1, addr_tab[3], '0);
    end_of_test();
  end
endmodule
bind sys_config_regs sys_config_regs_props i_sys_config_regs_props (.core_clk_i, .rst_n_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pslverr_o,
  .gpio_pins_i, .gpio_to_core_o, .core0_pad_i, .core1_pad_i, .core0_debug_o, .core1_debug_o,
  .core0_pad_detached_o, .core1_pad_detached_o, .memory_power_down_o);
